// ---- rtl/audio_dac_front_end.sv ----
`timescale 1ns/10ps

module audio_dac_front_end
	import audio_pkg::*;
#(
	parameter bit PIN_CONTROL = 1'b0
) (
	input  wire logic           clk_in,
	input  wire logic           rst_n_in,
	audio_link_if.sink          link,
	input  wire fmt_t           format_code_in,
	input  wire logic           format_select_in,
	input  wire logic           zero_flag_invert_in,
	input  wire logic           zero_flag_common_sel_in,
	output logic [23:0]         sample_data_out,
	output logic                sample_right_out,
	output logic                sample_valid_out,
	output logic                mid_level_reference_out,
	output os_rate_t            os_rate_out,
	output logic [2:0]          ratio_index_out,
	output logic                zero_flag_left_out,
	output logic                zero_flag_right_out
);
	localparam logic [15:0] RATIOS [`RATIO_COUNT] =
		'{16'd128, 16'd192, 16'd256, 16'd384, 16'd512, 16'd768, 16'd1152};

	dev_s_t         q;
	dev_s_t         n;
	logic           bclk;
	logic           ws;
	logic           din;
	logic           rise;
	logic           ws_rise;
	logic           fws;
	logic           is_i2s;
	logic           stalled;
	logic           rate_bad;
	logic           left_now;
	logic [23:0]    word;
	logic [15:0]    diff;
	logic           zl;
	logic           zr;
	logic           both;

	////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
		abs_diff = (a > b) ? a - b : b - a;
	endfunction

	function automatic logic [23:0] rj_word(input fmt_t f, input logic [23:0] sr);
		case (f)
			FMT_RJ20: rj_word = {{4{sr[19]}}, sr[19:0]};
			FMT_RJ18: rj_word = {{6{sr[17]}}, sr[17:0]};
			FMT_RJ16: rj_word = {{8{sr[15]}}, sr[15:0]};
			default:  rj_word = sr;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		n        = q;
		n.valid  = 1'b0;
		// pins pass two flops; only sync2 feeds logic
		n.sync1  = {link.bit_clock, link.word_select_clock, link.serial_data};
		n.sync2  = q.sync1;
		bclk     = q.sync2[2];
		ws       = q.sync2[1];
		din      = q.sync2[0];
		n.bclk_prev = bclk;
		n.ws_prev   = ws;
		rise     = bclk & ~q.bclk_prev;
		ws_rise  = ws & ~q.ws_prev;
		is_i2s   = q.fmt == FMT_I2S;
		// i2s framing uses word clock one bit late, then matches left justified
		fws      = is_i2s ? q.ws_bit : ws;
		left_now = 1'b0;
		word     = 24'h0;
		diff     = 16'h0;
		rate_bad = 1'b0;

		// bit clock stall over three periods
		n.gap_cnt = (q.gap_cnt == 16'hffff) ? q.gap_cnt : q.gap_cnt + 16'h1;
		stalled = (q.bclk_per != 16'h0) &&
			({2'b00, q.gap_cnt} > ({2'b00, q.bclk_per} * `GAP_PERIODS));
		if (rise)
		begin
			n.bclk_per = q.gap_cnt + 16'h1;
			n.gap_cnt  = 16'h0;
		end

		n.frame_cnt = (q.frame_cnt == 16'hffff) ? q.frame_cnt : q.frame_cnt + 16'h1;
		if (ws_rise)
		begin
			n.frame_cnt = 16'h1;
			if (q.frames_seen != 2'd3)
			begin
				n.frames_seen = q.frames_seen + 2'd1;
			end
			if (q.frames_seen >= 2'd2)
			begin
				diff = abs_diff(q.frame_cnt, RATIOS[q.ratio_idx]);
				rate_bad = !q.ratio_ok || (diff > `RATIO_TOL);
			end
			if (q.frames_seen >= 2'd1)
			begin
				n.ratio_ok = 1'b0;
				for (int i = 0; i < `RATIO_COUNT; i++)
				begin
					if (abs_diff(q.frame_cnt, RATIOS[i]) <= `RATIO_TOL)
					begin
						n.ratio_ok  = 1'b1;
						n.ratio_idx = 3'(i);
					end
				end
				if (n.ratio_idx >= `OS64_MIN_IDX)
				begin
					n.os = OS_64X;
				end
				else if (n.ratio_idx >= `OS32_MIN_IDX)
				begin
					n.os = OS_32X;
				end
				else
				begin
					n.os = OS_16X;
				end
			end
			// mode changes only at frame start so a word is never split
			n.invert     = zero_flag_invert_in;
			n.common_sel = zero_flag_common_sel_in;
			if (PIN_CONTROL)
			begin
				n.fmt = format_select_in ? FMT_RJ16 : FMT_I2S;
			end
			else
			begin
				n.fmt = format_code_in;
			end
		end

		if (rise)
		begin
			n.ws_bit     = ws;
			n.frame_prev = fws;
			n.sr         = {q.sr[22:0], din};
			if (fws != q.frame_prev)
			begin
				word     = (q.fmt <= FMT_RJ16) ? rj_word(q.fmt, q.sr) : q.acc;
				left_now = q.frame_prev ^ is_i2s;
				if (q.st == ST_RUN)
				begin
					n.valid = 1'b1;
					n.data  = word;
					n.right = ~left_now;
					if (left_now)
					begin
						n.zcnt_l = (word != 24'h0) ? 11'h0 :
							((q.zcnt_l == `ZERO_PERIODS) ? q.zcnt_l : q.zcnt_l + 11'h1);
					end
					else
					begin
						n.zcnt_r = (word != 24'h0) ? 11'h0 :
							((q.zcnt_r == `ZERO_PERIODS) ? q.zcnt_r : q.zcnt_r + 11'h1);
					end
				end
				n.acc = {din, 23'h0};
				n.pos = 6'h1;
			end
			else
			begin
				if (q.pos < 6'd24)
				begin
					n.acc[5'(6'd23 - q.pos)] = din;
				end
				n.pos = (q.pos == 6'h3f) ? q.pos : q.pos + 6'h1;
			end
		end

		case (q.st)
			ST_INIT:
			begin
				n.init_cnt    = q.init_cnt + 12'h1;
				n.frames_seen = 2'd0;
				n.zcnt_l      = 11'h0;
				n.zcnt_r      = 11'h0;
				if (q.init_cnt == `INIT_CYCLES - 12'h1)
				begin
					// defaults loaded at end of init
					n.fmt        = PIN_CONTROL ? FMT_I2S : FMT_LJ24;
					n.invert     = 1'b0;
					n.common_sel = 1'b0;
					n.st         = ST_SYNC;
				end
			end
			ST_SYNC:
			begin
				if (stalled)
				begin
					n.st          = ST_SUSP;
					n.frames_seen = 2'd0;
				end
				else if (rate_bad)
				begin
					n.frames_seen = 2'd1;
				end
				else if (q.frames_seen >= 2'd2 && q.ratio_ok)
				begin
					n.st = ST_RUN;
				end
			end
			ST_RUN:
			begin
				if (stalled || rate_bad)
				begin
					n.st          = ST_SUSP;
					n.frames_seen = 2'd0;
				end
			end
			ST_SUSP:
			begin
				n.frames_seen = 2'd0;
				// restart alone once bit clock returns
				if (rise)
				begin
					n.st = ST_SYNC;
				end
			end
			default:
			begin
				n.st = ST_INIT;
			end
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			q     <= '0;
			q.st  <= ST_INIT;
			q.fmt <= FMT_LJ24;
			q.os  <= OS_64X;
		end
		else
		begin
			q <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign sample_data_out  = q.data;
	assign sample_right_out = q.right;
	assign sample_valid_out = q.valid;
	assign os_rate_out      = q.os;
	assign ratio_index_out  = q.ratio_idx;
	assign mid_level_reference_out = q.st != ST_RUN;

	// flag high while zero condition holds
	assign zl   = q.zcnt_l == `ZERO_PERIODS;
	assign zr   = q.zcnt_r == `ZERO_PERIODS;
	assign both = zl & zr;
	assign zero_flag_left_out  = (q.common_sel ? both : zl) ^ q.invert;
	assign zero_flag_right_out = (q.common_sel ? both : zr) ^ q.invert;
endmodule

// ---- rtl/audio_defs.svh ----
// What this block does
// - system clock is 128 to 1152 times fs
// - count 3072 system clocks before leaving reset
// - load default mode settings after initialization
// - hold output at mid level during reset
// - start output after one clean sample period
// - shift serial data on bit clock rise
// - word clock edge latches channel word
// - source sends 32, 48 or 64 bits per frame
// - source derives link clocks from system clock
// - suspend on rate change or stopped clock
// - resynchronise alone within three sample periods
// - register variant takes RJ, I2S, LJ formats
// - pin variant takes I2S or RJ16 only
// - samples are two's complement, MSB first
// - word clock polarity depends on format
// - oversampling rate follows detected clock ratio
// - zero detect after 1024 zero sample periods
// - zero flag high while zero detected
// - invert and common settings shape zero flags
`ifndef AUDIO_DEFS_SVH
`define AUDIO_DEFS_SVH

`define SAMPLE_W        24
`define INIT_CYCLES     12'd3072
`define ZERO_PERIODS    11'd1024
`define GAP_PERIODS     18'd3
`define RATIO_TOL       16'd4
`define RATIO_COUNT     7
`define OS64_MIN_IDX    3'd4
`define OS32_MIN_IDX    3'd2
`define LJ_OFFSET       7'd0
`define FIFO_DEPTH      16
`define FRAME_BITS      64
`define BCLK_DIV_HALF   4

`endif

// ---- rtl/audio_pkg.sv ----
`include "audio_defs.svh"

package audio_pkg;

	typedef enum logic [2:0]
	{
		FMT_RJ24 = 3'h0,
		FMT_RJ20 = 3'h1,
		FMT_RJ18 = 3'h2,
		FMT_RJ16 = 3'h3,
		FMT_I2S  = 3'h4,
		FMT_LJ24 = 3'h5
	} fmt_t;

	typedef enum logic [3:0]
	{
		ST_INIT = 4'b0001,
		ST_SYNC = 4'b0010,
		ST_RUN  = 4'b0100,
		ST_SUSP = 4'b1000
	} dev_state_t;

	typedef enum logic [1:0]
	{
		OS_16X = 2'h0,
		OS_32X = 2'h1,
		OS_64X = 2'h2
	} os_rate_t;

	typedef struct packed
	{
		dev_state_t     st;
		logic [11:0]    init_cnt;
		logic [2:0]     sync1;
		logic [2:0]     sync2;
		logic           bclk_prev;
		logic           ws_prev;
		logic           ws_bit;
		logic           frame_prev;
		logic [5:0]     pos;
		logic [23:0]    acc;
		logic [23:0]    sr;
		logic [15:0]    gap_cnt;
		logic [15:0]    bclk_per;
		logic [15:0]    frame_cnt;
		logic [1:0]     frames_seen;
		fmt_t           fmt;
		logic           invert;
		logic           common_sel;
		os_rate_t       os;
		logic [2:0]     ratio_idx;
		logic           ratio_ok;
		logic [10:0]    zcnt_l;
		logic [10:0]    zcnt_r;
		logic [23:0]    data;
		logic           right;
		logic           valid;
	} dev_s_t;

	typedef struct packed
	{
		logic [7:0]     div_cnt;
		logic           bclk;
		logic [6:0]     bit_idx;
		logic           ws;
		logic           data;
		logic [47:0]    frame;
	} host_s_t;

endpackage

// ---- rtl/audio_link_if.sv ----
`timescale 1ns/10ps

interface audio_link_if;
	logic   bit_clock;
	logic   word_select_clock;
	logic   serial_data;

	modport source
	(
		output bit_clock,
		output word_select_clock,
		output serial_data
	);

	modport sink
	(
		input bit_clock,
		input word_select_clock,
		input serial_data
	);
endinterface

// ---- rtl/sample_fifo.sv ----
`timescale 1ns/10ps

module sample_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 16
) (
	input  wire logic               clk_in,
	input  wire logic               rst_n_in,
	input  wire logic               wr_valid_in,
	output logic                    wr_ready_out,
	input  wire logic [WIDTH-1:0]   wr_data_in,
	output logic                    rd_valid_out,
	input  wire logic               rd_ready_in,
	output logic [WIDTH-1:0]        rd_data_out
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed
	{
		logic [AW:0]    wr_ptr;
		logic [AW:0]    rd_ptr;
	} fifo_s_t;

	fifo_s_t            q;
	fifo_s_t            d;
	logic [WIDTH-1:0]   mem [DEPTH];
	logic               full;
	logic               empty;
	logic               push;
	logic               pop;

	////////////////////////////////////////////////////////////////////////
	// extra pointer bit tells full from empty
	assign full         = (q.wr_ptr[AW] != q.rd_ptr[AW]) && (q.wr_ptr[AW-1:0] == q.rd_ptr[AW-1:0]);
	assign empty        = q.wr_ptr == q.rd_ptr;
	assign wr_ready_out = ~full;
	assign rd_valid_out = ~empty;
	assign rd_data_out  = mem[q.rd_ptr[AW-1:0]];
	assign push         = wr_valid_in & ~full;
	assign pop          = rd_ready_in & ~empty;

	always_comb
	begin
		d = q;
		if (push)
		begin
			d.wr_ptr = q.wr_ptr + 1'b1;
		end
		if (pop)
		begin
			d.rd_ptr = q.rd_ptr + 1'b1;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (push)
		begin
			mem[q.wr_ptr[AW-1:0]] <= wr_data_in;
		end
	end
endmodule

// ---- rtl/audio_pcm_source.sv ----
`timescale 1ns/10ps

module audio_pcm_source
	import audio_pkg::*;
#(
	parameter int DIV_HALF   = `BCLK_DIV_HALF,
	parameter int FRAME_BITS = `FRAME_BITS,
	parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
	input  wire logic           clk_in,
	input  wire logic           rst_n_in,
	input  wire fmt_t           format_in,
	input  wire logic [23:0]    sample_left_in,
	input  wire logic [23:0]    sample_right_in,
	input  wire logic           sample_valid_in,
	output logic                sample_ready_out,
	audio_link_if.source        link
);
	localparam logic [6:0] LAST = 7'(FRAME_BITS - 1);
	localparam logic [6:0] HALF = 7'(FRAME_BITS / 2);

	host_s_t        q;
	host_s_t        n;
	logic           fifo_valid;
	logic [47:0]    fifo_data;
	logic           pop;
	logic [47:0]    cur;
	logic [47:0]    src;
	logic [23:0]    s;
	logic [6:0]     nxt;
	logic [6:0]     e;
	logic [6:0]     p;
	logic [6:0]     rj_start;
	logic           is_i2s;
	logic           is_rj;

	////////////////////////////////////////////////////////////////////////
	sample_fifo #(
		.WIDTH  (48),
		.DEPTH  (FIFO_DEPTH)
	) u_fifo (
		.clk_in         (clk_in),
		.rst_n_in       (rst_n_in),
		.wr_valid_in    (sample_valid_in),
		.wr_ready_out   (sample_ready_out),
		.wr_data_in     ({sample_left_in, sample_right_in}),
		.rd_valid_out   (fifo_valid),
		.rd_ready_in    (pop),
		.rd_data_out    (fifo_data)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		n        = q;
		pop      = 1'b0;
		is_i2s   = format_in == FMT_I2S;
		is_rj    = format_in <= FMT_RJ16;
		nxt      = (q.bit_idx == LAST) ? 7'h0 : q.bit_idx + 7'h1;
		cur      = q.frame;
		src      = q.frame;
		s        = 24'h0;
		e        = 7'h0;
		p        = 7'h0;
		case (format_in)
			FMT_RJ20: rj_start = HALF - 7'd20;
			FMT_RJ18: rj_start = HALF - 7'd18;
			FMT_RJ16: rj_start = HALF - 7'd16;
			default:  rj_start = HALF - 7'd24;
		endcase
		if (q.div_cnt == 8'(DIV_HALF - 1))
		begin
			n.div_cnt = 8'h0;
			n.bclk    = ~q.bclk;
			// change data on fall, stable at rise
			if (q.bclk)
			begin
				n.bit_idx = nxt;
				if (nxt == 7'h0)
				begin
					// empty fifo sends silence rather than stalling the link
					pop     = fifo_valid;
					cur     = fifo_valid ? fifo_data : 48'h0;
					n.frame = cur;
				end
				// i2s word clock leads msb by one bit
				e = is_i2s ? ((nxt == 7'h0) ? LAST : nxt - 7'h1) : nxt;
				src = (is_i2s && nxt == 7'h0) ? q.frame : cur;
				s = (e >= HALF) ? src[23:0] : src[47:24];
				p = (e >= HALF) ? e - HALF : e;
				// left is high except in i2s
				// data already lags one slot in i2s, so the word clock keeps frame slots
				n.ws = is_i2s ? (nxt >= HALF) : (nxt < HALF);
				if (is_rj)
				begin
					n.data = (p >= rj_start) ? s[5'(HALF - 7'h1 - p)] : 1'b0;
				end
				else
				begin
					n.data = (p < 7'd24) ? s[5'(7'd23 - p)] : 1'b0;
				end
			end
		end
		else
		begin
			n.div_cnt = q.div_cnt + 8'h1;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			q         <= '0;
			q.bit_idx <= 7'h7f;
		end
		else
		begin
			q <= n;
		end
	end

	assign link.bit_clock         = q.bclk;
	assign link.word_select_clock = q.ws;
	assign link.serial_data       = q.data;
endmodule

// ---- test/audio_link_chk.sv ----
`timescale 1ns/10ps

module audio_link_chk #(
	parameter int DIV_HALF   = 1,
	parameter int FRAME_BITS = 64
) (
	input  wire logic   clk_in,
	input  wire logic   rst_n_in,
	input  wire logic   bit_clock_in,
	input  wire logic   word_select_clock_in,
	input  wire logic   serial_data_in
);
	localparam int HALF_FR = FRAME_BITS * DIV_HALF;

	logic [7:0] ccnt_q;
	logic [7:0] wcnt_q;
	logic [7:0] bcnt_q;
	logic       cseen_q;
	logic       wseen_q;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	////////////////////////////////////////////////////////////////////////////////
	// first edges after reset are partial, so the seen flags gate them
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			ccnt_q  <= 8'h0;
			wcnt_q  <= 8'h0;
			bcnt_q  <= 8'h0;
			cseen_q <= 1'b0;
			wseen_q <= 1'b0;
		end
		else
		begin
			ccnt_q  <= $changed(bit_clock_in) ? 8'h0 : ccnt_q + 8'h1;
			wcnt_q  <= $changed(word_select_clock_in) ? 8'h0 : wcnt_q + 8'h1;
			bcnt_q  <= $changed(word_select_clock_in) ? 8'h0 : bcnt_q + 8'($rose(bit_clock_in));
			cseen_q <= cseen_q | $changed(bit_clock_in);
			wseen_q <= wseen_q | $changed(word_select_clock_in);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	property p_data_fall;
		$changed(serial_data_in) |-> $fell(bit_clock_in);
	endproperty
	a_data_fall: assert property (p_data_fall)
		else $error("data moved off a falling bit clock");
	property p_ws_fall;
		$changed(word_select_clock_in) |-> $fell(bit_clock_in);
	endproperty
	a_ws_fall: assert property (p_ws_fall)
		else $error("word clock moved off a falling bit clock");
	property p_half;
		$changed(bit_clock_in) && cseen_q |-> ccnt_q == 8'(DIV_HALF - 1);
	endproperty
	a_half: assert property (p_half)
		else $error("bit clock half period wrong");
	property p_frame;
		$changed(word_select_clock_in) && wseen_q |-> wcnt_q == 8'(HALF_FR - 1);
	endproperty
	a_frame: assert property (p_frame)
		else $error("word clock half period wrong");
	property p_bits;
		$changed(word_select_clock_in) && wseen_q |-> bcnt_q == 8'(FRAME_BITS / 2);
	endproperty
	a_bits: assert property (p_bits)
		else $error("bit count per channel wrong");
	property p_reset_idle;
		$rose(rst_n_in) |-> !bit_clock_in && !word_select_clock_in && !serial_data_in;
	endproperty
	a_reset_idle: assert property (p_reset_idle)
		else $error("link not idle in reset");
	property p_run;
		$fell(bit_clock_in) |-> ##[1:8] $rose(bit_clock_in);
	endproperty
	a_run: assert property (p_run)
		else $error("bit clock stalled");
	property p_ws_rate;
		$rose(word_select_clock_in) && wseen_q |-> ##HALF_FR $fell(word_select_clock_in);
	endproperty
	a_ws_rate: assert property (p_ws_rate)
		else $error("word clock rate wrong");
endmodule

// ---- test/dac_audio_input_front_end_tb.sv ----
`timescale 1ns/10ps

module dac_audio_input_front_end_tb import audio_pkg::*;;
	localparam int FR = 128;

	logic           clk_in;
	logic           rst_n;
	logic           src_rst_n;
	fmt_t           fmt;
	logic           pin_sel, inv, com, sv, rdy;
	logic [23:0]    sl, sr, d_data, p_data;
	logic           d_right, d_valid, d_mid, zl, zr, p_right, p_valid;
	os_rate_t       d_os, p_os;
	logic [2:0]     d_idx;
	logic [23:0]    last [2];
	logic [23:0]    plast [2];
	int             zcnt = 0;
	int             fails, checks_done, i, n;
	fmt_t           fl [6] = '{FMT_LJ24, FMT_I2S, FMT_RJ24, FMT_RJ20, FMT_RJ18, FMT_RJ16};
	int             wl [6] = '{24, 24, 24, 20, 18, 16};

	audio_link_if link ();
	audio_pcm_source #(.DIV_HALF(1)) i_audio_pcm_source (
		.clk_in(clk_in), .rst_n_in(src_rst_n), .format_in(fmt), .sample_left_in(sl),
		.sample_right_in(sr), .sample_valid_in(sv), .sample_ready_out(rdy), .link(link.source));
	audio_dac_front_end #(.PIN_CONTROL(1'b0)) i_audio_dac_front_end (
		.clk_in(clk_in), .rst_n_in(rst_n), .link(link.sink), .format_code_in(fmt),
		.format_select_in(pin_sel), .zero_flag_invert_in(inv), .zero_flag_common_sel_in(com),
		.sample_data_out(d_data), .sample_right_out(d_right), .sample_valid_out(d_valid),
		.mid_level_reference_out(d_mid), .os_rate_out(d_os), .ratio_index_out(d_idx),
		.zero_flag_left_out(zl), .zero_flag_right_out(zr));
	// pin variant listens on the same wires
	audio_dac_front_end #(.PIN_CONTROL(1'b1)) i_audio_dac_front_end_pin (
		.clk_in(clk_in), .rst_n_in(rst_n), .link(link.sink), .format_code_in(fmt),
		.format_select_in(pin_sel), .zero_flag_invert_in(inv), .zero_flag_common_sel_in(com),
		.sample_data_out(p_data), .sample_right_out(p_right), .sample_valid_out(p_valid),
		.mid_level_reference_out(), .os_rate_out(p_os), .ratio_index_out(),
		.zero_flag_left_out(), .zero_flag_right_out());
	audio_link_chk #(.DIV_HALF(1)) i_audio_link_chk (
		.clk_in(clk_in), .rst_n_in(src_rst_n), .bit_clock_in(link.bit_clock),
		.word_select_clock_in(link.word_select_clock), .serial_data_in(link.serial_data));

	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_in)
	begin
		if (d_valid === 1'b1)
		begin
			last[d_right] <= d_data;
			if (!d_right)
				zcnt <= (d_data == 24'h0) ? zcnt + 1 : 0;
		end
		if (p_valid === 1'b1)
			plast[p_right] <= p_data;
	end

	task end_sim;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task check(input string name, input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	function automatic logic [23:0] sx(input logic [23:0] v, input int w);
		logic [23:0] m;
		m = (24'h1 << w) - 24'h1;
		return v[w-1] ? (v | ~m) : (v & m);
	endfunction

	task push(input logic [23:0] l, input logic [23:0] r);
		int k;
		@(posedge clk_in);
		sl <= l;
		sr <= r;
		sv <= 1'b1;
		k = 0;
		@(negedge clk_in);
		while (rdy !== 1'b1 && k < 300)
		begin
			@(negedge clk_in);
			k++;
		end
		if (rdy !== 1'b1)
		begin
			fails++;
			end_sim;
		end
		@(posedge clk_in);
		sv <= 1'b0;
	endtask

	// waits sample on the falling edge so registered outputs have settled
	task wait_mid(input logic v, input int bound);
		int k;
		k = 0;
		@(negedge clk_in);
		while (d_mid !== v && k < bound)
		begin
			@(negedge clk_in);
			k++;
		end
		if (d_mid !== v)
		begin
			fails++;
			end_sim;
		end
	endtask

	task wait_zero(input int target);
		int k;
		k = 0;
		while (zcnt < target && k < 200000)
		begin
			@(negedge clk_in);
			k++;
		end
		if (zcnt < target)
		begin
			fails++;
			end_sim;
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		{rst_n, src_rst_n, pin_sel, inv, com, sv} = 6'h0;
		fmt = FMT_LJ24;
		sl = 24'h0;
		sr = 24'h0;
		fails = 0;
		checks_done = 0;
		repeat (4) @(posedge clk_in);
		#1 check("mid", d_mid, 24'h1);
		check("valid", d_valid, 24'h0);
		repeat (4) @(posedge clk_in);
		rst_n <= 1'b1;
		src_rst_n <= 1'b1;
		repeat (3071) @(posedge clk_in);
		#1 check("mid", d_mid, 24'h1);
		wait_mid(1'b0, 4 * FR);
		check("os", d_os, OS_16X);
		check("ratio", d_idx, 24'h0);
		check("os pin", p_os, OS_16X);
		// each pass holds the source in reset, which stalls the link, so every pass also resyncs
		for (i = 0; i < 6; i++)
		begin
			@(posedge clk_in);
			src_rst_n <= 1'b0;
			fmt <= fl[i];
			pin_sel <= (fl[i] == FMT_RJ16);
			repeat (20) @(posedge clk_in);
			#1 check("suspend", d_mid, 24'h1);
			@(posedge clk_in);
			src_rst_n <= 1'b1;
			wait_mid(1'b0, 3 * FR);
			repeat (6) push(24'h9a5c31, 24'h3c0f7e);
			repeat (5 * FR) @(negedge clk_in);
			check("left", last[0], sx(24'h9a5c31, wl[i]));
			check("right", last[1], sx(24'h3c0f7e, wl[i]));
			if (fl[i] == FMT_I2S || fl[i] == FMT_RJ16)
			begin
				check("pin left", plast[0], sx(24'h9a5c31, wl[i]));
				check("pin right", plast[1], sx(24'h3c0f7e, wl[i]));
			end
		end
		n = 0;
		repeat (20)
		begin
			@(negedge clk_in);
			if (rdy === 1'b1)
			begin
				push(24'h0, 24'h0);
				n++;
			end
		end
		@(negedge clk_in);
		check("full", {rdy, 1'(n >= 15)}, 24'h1);
		wait_zero(1000);
		check("zero early", zl, 24'h0);
		wait_zero(1030);
		check("zero left", zl, 24'h1);
		check("zero right", zr, 24'h1);
		@(posedge clk_in);
		inv <= 1'b1;
		repeat (2 * FR) @(negedge clk_in);
		check("inverted", {zl, zr}, 24'h0);
		@(posedge clk_in);
		inv <= 1'b0;
		push(24'h000005, 24'h0);
		repeat (4 * FR) @(negedge clk_in);
		check("split", {zl, zr}, 24'h1);
		@(posedge clk_in);
		com <= 1'b1;
		repeat (2 * FR) @(negedge clk_in);
		check("common", {zl, zr}, 24'h0);
		end_sim;
	end
endmodule
